// ==== include/bmd_regs.svh ====
/*
  Address map constants for the banked data memory decoder.
  Assumes a 12-bit data address, 7-bit in-bank offset and 5-bit bank number.
*/
`ifndef BMD_REGS_SVH
`define BMD_REGS_SVH

`define BMD_ADDR_W        12
`define BMD_OFS_W         7
`define BMD_BANK_W        5
`define BMD_NUM_BANKS     32
`define BMD_BANK_BYTES    128
`define BMD_CORE_LAST     7'h0B
`define BMD_PERIPH_FIRST  7'h0C
`define BMD_PERIPH_LAST   7'h1F
`define BMD_RAM_FIRST     7'h20
`define BMD_RAM_LAST      7'h6F
`define BMD_COMMON_FIRST  7'h70
`define BMD_RAM_BANKS     5'h03
`define BMD_RAM_BYTES     80
`define BMD_GRAM_DEPTH    240
`define BMD_COMMON_BYTES  16
`define BMD_LIN_BASE      16'h2000
`define BMD_LIN_SPAN      16'h00F0
`define BMD_SEL_W         640
`define BMD_PERIPH_SPAN   10'h014
`define BMD_BANK_RESET    5'h00

`endif

// ==== include/bmd_pkg.sv ====
/*
  Types for the banked data memory decoder.
  Assumes bmd_regs.svh is on the include path.
*/
`include "bmd_regs.svh"
package bmd_pkg;
  typedef enum logic [2:0] {
    BMD_REG_CORE,
    BMD_REG_PERIPH,
    BMD_REG_RAM,
    BMD_REG_COMMON,
    BMD_REG_NONE
  } bmd_region_type;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic                   indirect;
    logic [15:0]            ptr;
    logic [`BMD_OFS_W-1:0]  ofs;
    logic [7:0]             wdata;
  } bmd_req_type;
endpackage

// ==== core/bmd_decoder.sv ====
/*
  Banked data memory decoder with general and common RAM arrays.
  Assumes the core presents one access per enabled cycle on the same clock
  and holds core register and peripheral register contents elsewhere.
*/
`timescale 1ns/1ps
`include "bmd_regs.svh"

// Functional notes
// RULE1 - Offsets 0Ch-1Fh go to peripheral window.
// RULE2 - No more than 80 RAM bytes per bank.
// RULE3 - RAM only in banks 0, 1, 2.
// RULE4 - Sixteen byte common RAM from every bank.
// RULE5 - Offsets 70h-7Fh reach shared common bytes.
// RULE6 - Empty locations read zero, ignore writes.
// RULE7 - Banks 3 up: 20h-6Fh read zero.
// RULE8 - Pointer sees RAM as linear region.
// RULE9 - Address: five bank bits, seven offset bits.
// RULE10 - Thirty-two banks of 128 bytes.
// RULE11 - First twelve offsets are core registers.
// RULE12 - Direct bank comes from bank select.
// RULE13 - One peripheral select per implemented offset.
module bmd_decoder (
  input  wire logic                     sys_clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     clk_en_in,
  input  wire logic                     bank_wr_in,
  input  wire logic [`BMD_BANK_W-1:0]   bank_wdata_in,
  input  wire bmd_pkg::bmd_req_type     req_in,
  input  wire logic [`BMD_SEL_W-1:0]    periph_impl_in,
  input  wire logic [7:0]               periph_rdata_in,
  output logic [`BMD_BANK_W-1:0]        active_bank_select_out,
  output logic [`BMD_ADDR_W-1:0]        addr_out,
  output bmd_pkg::bmd_region_type       region_out,
  output logic [`BMD_SEL_W-1:0]         periph_sel_out,
  output logic                          periph_wr_out,
  output logic [7:0]                    wdata_out,
  output logic                          rvalid_out,
  output logic [7:0]                    rdata_out
);

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  function automatic bmd_pkg::bmd_region_type region_of(input logic [`BMD_ADDR_W-1:0] a);
    logic [`BMD_OFS_W-1:0]  o;
    logic [`BMD_BANK_W-1:0] b;
    o = a[`BMD_OFS_W-1:0];
    b = a[`BMD_ADDR_W-1:`BMD_OFS_W];                                 // RULE10
    if (o <= `BMD_CORE_LAST)
      region_of = bmd_pkg::BMD_REG_CORE;                             // RULE11
    else if (o <= `BMD_PERIPH_LAST)
      region_of = bmd_pkg::BMD_REG_PERIPH;                           // RULE1
    else if (o >= `BMD_COMMON_FIRST)
      region_of = bmd_pkg::BMD_REG_COMMON;                           // RULE5
    else if (b < `BMD_RAM_BANKS)
      region_of = bmd_pkg::BMD_REG_RAM;                              // RULE3
    else
      region_of = bmd_pkg::BMD_REG_NONE;                             // RULE7
  endfunction

  function automatic logic [7:0] ram_index(input logic [`BMD_ADDR_W-1:0] a);
    logic [7:0] base;
    base = 8'(a[`BMD_ADDR_W-1:`BMD_OFS_W]) * 8'h50;                  // RULE2
    ram_index = 8'(base + 8'(a[`BMD_OFS_W-1:0] - `BMD_RAM_FIRST));
  endfunction

  function automatic logic [9:0] periph_index(input logic [`BMD_ADDR_W-1:0] a);
    logic [9:0] base;
    base = 10'(a[`BMD_ADDR_W-1:`BMD_OFS_W]) * `BMD_PERIPH_SPAN;
    periph_index = 10'(base + 10'(a[`BMD_OFS_W-1:0] - `BMD_PERIPH_FIRST));
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] gram [`BMD_GRAM_DEPTH];
  logic [7:0] cram [`BMD_COMMON_BYTES];

  logic [`BMD_BANK_W-1:0]  next_bank;
  logic [`BMD_ADDR_W-1:0]  next_addr;
  bmd_pkg::bmd_region_type next_region;
  logic [`BMD_SEL_W-1:0]   next_sel;
  logic                    next_pwr;
  logic [7:0]              next_wdata;
  logic                    next_rvalid;
  logic [7:0]              next_rdata;
  logic [`BMD_ADDR_W-1:0]  cur_addr;
  bmd_pkg::bmd_region_type cur_region;
  logic                    lin_hit;
  logic [15:0]             lin_ofs;
  logic [7:0]              gidx;
  logic [9:0]              pidx;
  logic [`BMD_SEL_W-1:0]   sel_hit;
  logic                    gram_we;
  logic                    cram_we;

  // ----------------------------------------------------------------
  // Peripheral select decoder
  // ----------------------------------------------------------------
  // One comparator per select line, so a register only ever sees
  // its own offset in its own bank.
  for (genvar g = 0; g < `BMD_SEL_W; g++)
  begin : g_sel
    assign sel_hit[g] = (pidx == 10'(g));                            // RULE13
  end

  // ----------------------------------------------------------------
  // Bank select state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_bank = active_bank_select_out;
    if (bank_wr_in)
      next_bank = bank_wdata_in;                                     // RULE12
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      active_bank_select_out <= `BMD_BANK_RESET;
    else if (clk_en_in)
      active_bank_select_out <= next_bank;
  end

  // ----------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------
  always_comb
  begin
    lin_ofs = 16'(req_in.ptr - `BMD_LIN_BASE);
    lin_hit = req_in.indirect && (req_in.ptr >= `BMD_LIN_BASE) &&
              (lin_ofs < `BMD_LIN_SPAN);                             // RULE8
    if (req_in.indirect)
      cur_addr = req_in.ptr[`BMD_ADDR_W-1:0];
    else
      cur_addr = {active_bank_select_out, req_in.ofs};               // RULE9
    cur_region = lin_hit ? bmd_pkg::BMD_REG_RAM : region_of(cur_addr);
    gidx = lin_hit ? lin_ofs[7:0] : ram_index(cur_addr);
    pidx = periph_index(cur_addr);
  end

  // ----------------------------------------------------------------
  // Access response
  // ----------------------------------------------------------------
  always_comb
  begin
    next_addr = cur_addr;
    next_region = cur_region;
    next_sel = '0;
    next_pwr = 1'b0;
    next_wdata = req_in.wdata;
    next_rvalid = req_in.valid && !req_in.write;
    next_rdata = 8'h00;                                              // RULE6
    if (req_in.valid && cur_region == bmd_pkg::BMD_REG_PERIPH)
    begin
      next_sel = periph_impl_in & sel_hit;                           // RULE1
      next_pwr = req_in.write;
    end
    if (req_in.valid && !req_in.write)
    begin
      if (cur_region == bmd_pkg::BMD_REG_RAM)
        next_rdata = gram[gidx];
      else if (cur_region == bmd_pkg::BMD_REG_COMMON)
        next_rdata = cram[cur_addr[3:0]];                            // RULE4
      else if (|next_sel)
        next_rdata = periph_rdata_in;                                // RULE13
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      addr_out <= '0;
      region_out <= bmd_pkg::BMD_REG_NONE;
      periph_sel_out <= '0;
      periph_wr_out <= 1'b0;
      wdata_out <= 8'h00;
      rvalid_out <= 1'b0;
      rdata_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      addr_out <= next_addr;
      region_out <= next_region;
      periph_sel_out <= next_sel;
      periph_wr_out <= next_pwr;
      wdata_out <= next_wdata;
      rvalid_out <= next_rvalid;
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // RAM write path
  // ----------------------------------------------------------------
  always_comb
  begin
    gram_we = 1'b0;
    cram_we = 1'b0;
    if (clk_en_in && req_in.valid && req_in.write)
    begin
      gram_we = (cur_region == bmd_pkg::BMD_REG_RAM);                // RULE3
      cram_we = (cur_region == bmd_pkg::BMD_REG_COMMON);             // RULE5
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (gram_we)
      gram[gidx] <= req_in.wdata;
    if (cram_we)
      cram[cur_addr[3:0]] <= req_in.wdata;
  end

endmodule

// ==== bench/bmd_decoder_properties.sv ====
/* Port checker for the banked data memory decoder.
   Assumes it is bound into bmd_decoder; clk_en_in may drop at any edge. */
`timescale 1ns/1ps
module bmd_decoder_properties (
  input wire logic                    sys_clk_in,
  input wire logic                    resetn_in,
  input wire logic                    clk_en_in,
  input wire logic                    bank_wr_in,
  input wire logic [4:0]              bank_wdata_in,
  input wire bmd_pkg::bmd_req_type    req_in,
  input wire logic [639:0]            periph_impl_in,
  input wire logic [7:0]              periph_rdata_in,
  input wire logic [4:0]              active_bank_select_out,
  input wire logic [11:0]             addr_out,
  input wire bmd_pkg::bmd_region_type region_out,
  input wire logic [639:0]            periph_sel_out,
  input wire logic                    periph_wr_out,
  input wire logic [7:0]              wdata_out,
  input wire logic                    rvalid_out,
  input wire logic [7:0]              rdata_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  wire       tk = clk_en_in && req_in.valid && !req_in.indirect;
  wire [6:0] o  = req_in.ofs;
  wire       hi = active_bank_select_out >= 5'h03;
  chk_read_answer:
    assert property (clk_en_in && req_in.valid && !req_in.write |=> rvalid_out) else $error("no answer");
  chk_sel_onehot:
    assert property ($onehot0(periph_sel_out)) else $error("several selects");
  chk_core_map:
    assert property (tk && o <= 7'h0B |=> region_out == bmd_pkg::BMD_REG_CORE) else $error("core");
  chk_periph_map:
    assert property (tk && o inside {[7'h0C:7'h1F]} |=> region_out == bmd_pkg::BMD_REG_PERIPH)
      else $error("periph");
  chk_high_none:
    assert property (tk && hi && o inside {[7'h20:7'h6F]} |=> region_out == bmd_pkg::BMD_REG_NONE)
      else $error("high bank");
  chk_common_map:
    assert property (tk && o >= 7'h70 |=> region_out == bmd_pkg::BMD_REG_COMMON) else $error("common");
  chk_none_zero:
    assert property (rvalid_out && region_out == bmd_pkg::BMD_REG_NONE |-> rdata_out == 8'h00)
      else $error("none not zero");
  chk_bank_load:
    assert property (clk_en_in && bank_wr_in |=> active_bank_select_out == $past(bank_wdata_in))
      else $error("bank load");
  chk_periph_gap:
    assert property (rvalid_out && region_out == bmd_pkg::BMD_REG_PERIPH && !(|periph_sel_out)
      |-> rdata_out == 8'h00) else $error("empty peripheral offset not zero");
  chk_freeze_bank:
    assert property (!clk_en_in |=> $stable(active_bank_select_out)) else $error("bank moved");
  cover property (!clk_en_in && req_in.valid);
  cover property (rvalid_out && region_out == bmd_pkg::BMD_REG_COMMON);
  cover property (|periph_sel_out);
  cover property (req_in.valid && req_in.indirect);
endmodule
bind bmd_decoder bmd_decoder_properties u_bmd_decoder_properties (.*);

// ==== bench/bmd_periph_model.sv ====
/* Peripheral read data source for the decoder.
   Assumes the decoder samples it at each request edge. */
`timescale 1ns/1ps
module bmd_periph_model (
  input wire logic  sys_clk_in,
  input wire logic  resetn_in,
  output logic [7:0] rdata_out
);
  // Read data changes every cycle, so a stale sample never matches.
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) rdata_out <= 8'h3C;
    else rdata_out <= rdata_out + 8'h1D;
endmodule

// ==== bench/bmd_decoder_tb.sv ====
/* Self-checking bench for the decoder.
   Assumes the checker and the peripheral model are compiled before it. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module bmd_decoder_tb;
  logic clk = 1'b0, rst_n = 1'b0, bwr = 1'b0, pwr, rv, e_chk = 1'b0, e_rv = 1'b0, e_pwr, e_ok;
  logic ce = 1'b1;
  logic [4:0] bwd = 5'h00, bank, cur = 5'h00;
  logic [7:0] prd, wd, rd, e_rd, mem [256];
  logic [11:0] addr, e_addr;
  logic [639:0] impl = '0, sel, e_sel;
  bmd_pkg::bmd_req_type req = '0;
  bmd_pkg::bmd_region_type rg, e_rg;
  bit known [256];
  int failures = 0, cmp_count = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000) final_report(1'b1);
  end
  bmd_decoder u_bmd_decoder (.sys_clk_in(clk), .resetn_in(rst_n), .clk_en_in(ce),
    .bank_wr_in(bwr), .bank_wdata_in(bwd), .req_in(req), .periph_impl_in(impl),
    .periph_rdata_in(prd), .active_bank_select_out(bank), .addr_out(addr), .region_out(rg),
    .periph_sel_out(sel), .periph_wr_out(pwr), .wdata_out(wd), .rvalid_out(rv), .rdata_out(rd));
  bmd_periph_model u_bmd_periph_model (.sys_clk_in(clk), .resetn_in(rst_n), .rdata_out(prd));
  task final_report(input bit tmo);
    if (tmo) failures++;
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task step(input bit v, w, ind, input logic [15:0] p, input logic [6:0] o,
            input logic [7:0] d, input bit bw, input logic [4:0] bd);
    int i;
    @(negedge clk);
    `CHK("bank", cur, bank)
    `CHK("rvalid", e_rv, rv)
    if (e_chk)
    begin
      `CHK("region", e_rg, rg)
      `CHK("addr", e_addr, addr)
      `CHK("select", e_sel, sel)
      `CHK("pwrite", e_pwr, pwr)
      if (e_rv && e_ok) `CHK("rdata", e_rd, rd)
    end
    req = {v, w, ind, p, o, d};
    ce = 1'b1;
    bwr = bw;
    bwd = bd;
    e_addr = ind ? p[11:0] : {cur, o};
    i = 256;
    e_sel = '0;
    if (ind && p >= 16'h2000 && p < 16'h20F0) i = p - 16'h2000;
    if (i < 256) e_rg = bmd_pkg::BMD_REG_RAM;
    else if (e_addr[6:0] <= 7'h0B) e_rg = bmd_pkg::BMD_REG_CORE;
    else if (e_addr[6:0] <= 7'h1F) e_rg = bmd_pkg::BMD_REG_PERIPH;
    else if (e_addr[6:0] >= 7'h70) e_rg = bmd_pkg::BMD_REG_COMMON;
    else if (e_addr[11:7] < 5'h03) e_rg = bmd_pkg::BMD_REG_RAM;
    else e_rg = bmd_pkg::BMD_REG_NONE;
    if (e_rg == bmd_pkg::BMD_REG_PERIPH) e_sel[e_addr[11:7] * 20 + e_addr[6:0] - 12] =
      impl[e_addr[11:7] * 20 + e_addr[6:0] - 12];
    if (e_rg == bmd_pkg::BMD_REG_COMMON) i = 240 + e_addr[3:0];
    if (e_rg == bmd_pkg::BMD_REG_RAM && i == 256) i = e_addr[11:7] * 80 + e_addr[6:0] - 32;
    e_ok = (i == 256 || known[i]);
    e_rd = e_rg == bmd_pkg::BMD_REG_PERIPH ? (e_sel != '0 ? prd : 8'h00) :
           i < 256 ? mem[i] : 8'h00;
    e_chk = v;
    e_rv = v && !w;
    e_pwr = v && w && e_rg == bmd_pkg::BMD_REG_PERIPH;
    if (v && w && i < 256) {mem[i], known[i]} = {d, 1'b1};
    if (bw) cur = bd;
  endtask
  task hold(input int n);
    repeat (n)
    begin
      @(negedge clk);
      `CHK("frozen bank", cur, bank)
      `CHK("frozen rvalid", e_rv, rv)
      ce = 1'b0;
      req = {1'b1, 1'b1, 1'b0, 16'($urandom), 7'($urandom), 8'($urandom)};
      bwr = 1'b1;
      bwd = 5'($urandom);
    end
  endtask
  initial
  begin
    int k;
    int cs [4] = '{0, 79, 80, 239};
    logic [15:0] p;
    void'($urandom(28173));
    for (k = 0; k < 640; k++) impl[k] = 1'($urandom_range(1));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (k = 0; k < 4; k++)
    begin
      step(1, 1, 1, 16'h2000 + 16'(cs[k]), 7'h00, 8'(cs[k] + 90), 0, 5'h00);
      step(1, 0, 1, 16'(cs[k] / 80 * 128 + 32 + cs[k] % 80), 7'h00, 8'h00, 0, 5'h00);
    end
    step(1, 1, 0, 16'h0000, 7'h7F, 8'hC3, 1, 5'h1F);
    step(1, 0, 0, 16'h0000, 7'h7F, 8'h00, 0, 5'h00);
    repeat (3000)
    begin
      if ($urandom_range(15) == 0) hold($urandom_range(3, 1));
      p = $urandom_range(1) ? 16'h2000 + 16'($urandom_range(239)) : 16'($urandom_range(4095));
      step($urandom_range(7) != 0, $urandom_range(1), $urandom_range(2) == 0, p, 7'($urandom),
           8'($urandom), $urandom_range(3) == 0, 5'($urandom_range(1) ? 3 : 31) & 5'($urandom));
    end
    step(0, 0, 0, 16'h0000, 7'h00, 8'h00, 0, 5'h00);
    final_report(1'b0);
  end
endmodule
